// [hsfs_params.svh]
// Constants for the hotswap fault sequencer
`ifndef HSFS_PARAMS_SVH
`define HSFS_PARAMS_SVH

// Timing figures in their own units
`define HSFS_CLK_MHZ       50
`define HSFS_PG_DGL_US     9000
`define HSFS_POR_QUAL_US   400

// Counter widths sized for the default figures
`define HSFS_DGL_W         19
`define HSFS_POR_W         15
`define HSFS_RUN_W         20

// Retry sequence
`define HSFS_RETRY_W       4
`define HSFS_RETRY_LAST    4'hF
`define HSFS_RETRY_ZERO    4'h0
`define HSFS_RETRY_ONE     4'h1

// Register byte addresses
`define HSFS_ADDR_W        12
`define HSFS_ADDR_STATUS   12'h000
`define HSFS_ADDR_MASK     12'h004
`define HSFS_ADDR_INFO     12'h008

// Status and mask layout
`define HSFS_EV_W          4
`define HSFS_EV_FAULT      0
`define HSFS_EV_PG_RISE    1
`define HSFS_EV_PG_FALL    2
`define HSFS_EV_RESTART    3
`define HSFS_MASK_RST      4'h0
`define HSFS_DATA_ZERO     32'h0000_0000

`endif

// [hsfs_pkg.sv]
// Types shared by the hotswap fault sequencer modules
`default_nettype none
package hsfs_pkg;

  // Synchronous comparator results
  typedef struct packed {
    logic limit_active;
    logic timer_upper;
    logic timer_lower;
    logic vds_low;
    logic vds_high;
    logic uv_cleared;
    logic por_ok;
    logic enable_high;
    logic id_below_allowed;
    logic plim_over_clamp;
  } hsfs_flags_t;

  // Gate driver controls
  typedef struct packed {
    logic full_on;
    logic regulate;
    logic ref_clamp;
    logic weak_pd;
    logic strong_pd;
  } hsfs_gate_t;

  // Fault timer current controls
  typedef struct packed {
    logic charge;
    logic discharge;
    logic reset;
  } hsfs_timer_t;

  typedef enum logic [2:0] {
    S_OFF       = 3'h0,
    S_IDLE      = 3'h1,
    S_RUN       = 3'h3,
    S_RETRY_DIS = 3'h2,
    S_RETRY_CHG = 3'h6,
    S_LATCHED   = 3'h7
  } hsfs_state_t;

endpackage
`default_nettype wire

// [hsfs_por_qual.sv]
// Power-on-reset qualification timer for the hotswap supply
`default_nettype none
`include "hsfs_params.svh"
module hsfs_por_qual
  import hsfs_pkg::*;
#(
  parameter int QUAL_CYC = `HSFS_POR_QUAL_US * `HSFS_CLK_MHZ
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // Comparator flag and qualified result
  input  wire logic por_ok,
  output var  logic por_done
);
  localparam logic [`HSFS_POR_W-1:0] LAST = `HSFS_POR_W'(QUAL_CYC - 1);

  logic [`HSFS_POR_W-1:0] cnt;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt      <= '0;
      por_done <= 1'b0;
    end else if (!por_ok) begin
      cnt      <= '0;
      por_done <= 1'b0;
    end else if (cnt == LAST) begin
      por_done <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule
`default_nettype wire

// [hsfs_pg_deglitch.sv]
// Power-good deglitch filter on the pass transistor voltage
`default_nettype none
`include "hsfs_params.svh"
module hsfs_pg_deglitch
  import hsfs_pkg::*;
#(
  parameter int DGL_CYC = `HSFS_PG_DGL_US * `HSFS_CLK_MHZ
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // Comparator flags and forced clear
  input  wire logic vds_low,
  input  wire logic vds_high,
  input  wire logic clear,
  // Filtered result
  output var  logic power_good
);
  localparam logic [`HSFS_DGL_W-1:0] LAST = `HSFS_DGL_W'(DGL_CYC - 1);

  logic [`HSFS_DGL_W-1:0] cnt;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt        <= '0;
      power_good <= 1'b0;
    end else if (clear || vds_high) begin
      cnt        <= '0;
      power_good <= 1'b0;
    // Band between thresholds keeps the output as is
    end else if (!vds_low) begin
      cnt <= '0;
    end else if (cnt == LAST) begin
      power_good <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule
`default_nettype wire

// [hsfs_sequencer.sv]
// Hotswap fault sequencer: gate, timer, power-good control and APB registers
//
// The APB slave port and the register addresses were left to the implementer.
`default_nettype none
`include "hsfs_params.svh"
// Summary of operation
// - Gate drives only when supply and enable good
// - Latched fault clears on enable or undervoltage cycle
// - Power good after low drain voltage deglitch
// - Power good low on high drain voltage
// - Deglitch counter cleared at once on undervoltage
// - Program pin pulled low when off or latched
// - Gate full on below allowed current, else regulated
// - Allowed current clamped to fixed sense ceiling
// - Timer charges while limiting, else slow discharge
// - Latch-off mode latches gate low on expiry
// - Auto-retry runs fifteen timer cycles before restart
// - Timer discharged when enable or supply drops
// - Gate drive, power good and reference off while supply not qualified
// - Operation waits for qualified power-on and undervoltage
// - Reference output enabled only with supply qualified
// - Weak gate pulldown on enable or undervoltage fall
module hsfs_sequencer
  import hsfs_pkg::*;
#(
  parameter int PG_DGL_CYC   = `HSFS_PG_DGL_US * `HSFS_CLK_MHZ,
  parameter int POR_QUAL_CYC = `HSFS_POR_QUAL_US * `HSFS_CLK_MHZ
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`HSFS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  // Configuration and comparators
  input  wire logic                   retry_mode,
  input  wire hsfs_flags_t            flags,
  // Analog controls
  output var  hsfs_gate_t             gate,
  output var  hsfs_timer_t            timer,
  output var  logic                   power_limit_program_input_pulldown,
  output var  logic                   vref_enable,
  output var  logic                   power_good,
  // Interrupt
  output var  logic                   irq
);

  hsfs_state_t              state;
  hsfs_state_t              next_state;
  logic [`HSFS_RETRY_W-1:0] retry_cnt;
  logic [`HSFS_RETRY_W-1:0] next_retry_cnt;
  logic                     por_done;
  logic                     supply_ok;
  logic                     run_ok;
  logic                     pg_prev;
  logic [`HSFS_EV_W-1:0]    status;
  logic [`HSFS_EV_W-1:0]    mask;
  logic [`HSFS_EV_W-1:0]    events;
  logic [`HSFS_EV_W-1:0]    clr_bits;
  logic [`HSFS_EV_W-1:0]    next_status;
  logic                     acc_setup;
  logic                     acc_done;
  logic                     hit_status;
  logic                     hit_mask;
  logic                     hit_info;
  logic                     hit_any;
  logic                     wr_mask;
  logic                     rd_status;
  logic [31:0]              rd_val;
  logic                     ns_run;
  logic                     ns_off_idle;
  logic                     ns_retry;
  logic                     retry_done;

  hsfs_por_qual #(
    .QUAL_CYC (POR_QUAL_CYC)
  ) u_por_qual (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .por_ok   (flags.por_ok),
    .por_done (por_done)
  );

  hsfs_pg_deglitch #(
    .DGL_CYC    (PG_DGL_CYC)
  ) u_pg_deglitch (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .vds_low    (flags.vds_low),
    .vds_high   (flags.vds_high),
    .clear      (~supply_ok),
    .power_good (power_good)
  );

  assign supply_ok = por_done & flags.por_ok & flags.uv_cleared;
  assign run_ok    = supply_ok & flags.enable_high;

  assign retry_done = retry_cnt == `HSFS_RETRY_LAST;

  always_comb begin
    next_state = state;
    if (!supply_ok) begin
      next_state = S_OFF;
    end else begin
      unique case (state)
        S_OFF: begin
          next_state = S_IDLE;
        end
        S_IDLE: begin
          if (flags.enable_high) begin
            next_state = S_RUN;
          end
        end
        S_RUN: begin
          if (!flags.enable_high) begin
            next_state = S_IDLE;
          end else if (flags.timer_upper) begin
            next_state = retry_mode ? S_RETRY_DIS : S_LATCHED;
          end
        end
        S_RETRY_DIS: begin
          if (!flags.enable_high) begin
            next_state = S_IDLE;
          end else if (flags.timer_lower) begin
            next_state = retry_done ? S_RUN : S_RETRY_CHG;
          end
        end
        S_RETRY_CHG: begin
          if (!flags.enable_high) begin
            next_state = S_IDLE;
          end else if (flags.timer_upper) begin
            next_state = S_RETRY_DIS;
          end
        end
        S_LATCHED: begin
          // only an enable or supply cycle frees it
          if (!flags.enable_high) begin
            next_state = S_IDLE;
          end
        end
        default: begin
          next_state = S_OFF;
        end
      endcase
    end
  end

  always_comb begin
    next_retry_cnt = retry_cnt;
    // any dropped condition restarts the count
    if (!run_ok || next_state == S_RUN) begin
      next_retry_cnt = `HSFS_RETRY_ZERO;
    end else if (state == S_RETRY_CHG && next_state == S_RETRY_DIS) begin
      next_retry_cnt = retry_cnt + `HSFS_RETRY_ONE;
    end
  end

  // Outputs decode the next state so they line up with it
  assign ns_run      = next_state == S_RUN;
  assign ns_off_idle = next_state == S_OFF || next_state == S_IDLE;
  assign ns_retry    = next_state == S_RETRY_DIS || next_state == S_RETRY_CHG;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= S_OFF;
      retry_cnt <= `HSFS_RETRY_ZERO;
    end else begin
      state     <= next_state;
      retry_cnt <= next_retry_cnt;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gate          <= '0;
      timer         <= '0;
      power_limit_program_input_pulldown <= 1'b0;
      vref_enable   <= 1'b0;
    end else begin
      gate.full_on   <= ns_run & flags.id_below_allowed;
      gate.regulate  <= ns_run & ~flags.id_below_allowed;
      gate.ref_clamp <= ns_run & flags.plim_over_clamp;
      // weak pulldown for enable or supply fall
      gate.weak_pd   <= ns_off_idle;
      gate.strong_pd <= ns_retry || next_state == S_LATCHED;
      // charge while limiting, slow discharge otherwise
      timer.charge    <= (ns_run & flags.limit_active) || next_state == S_RETRY_CHG;
      timer.discharge <= (ns_run & ~flags.limit_active) || next_state == S_RETRY_DIS;
      timer.reset     <= ns_off_idle || next_state == S_LATCHED;
      power_limit_program_input_pulldown  <= ns_off_idle || next_state == S_LATCHED;
      // reference only with a qualified supply
      vref_enable    <= supply_ok;
    end
  end

  // Interrupt sources
  assign events[`HSFS_EV_FAULT]   = state == S_RUN && next_state != S_RUN
                                    && run_ok;
  assign events[`HSFS_EV_PG_RISE] = power_good & ~pg_prev;
  assign events[`HSFS_EV_PG_FALL] = ~power_good & pg_prev;
  assign events[`HSFS_EV_RESTART] = state == S_RETRY_DIS && next_state == S_RUN;

  // APB decode
  assign acc_setup  = psel & ~penable;
  assign acc_done   = psel & penable & pready;
  assign hit_status = paddr == `HSFS_ADDR_STATUS;
  assign hit_mask   = paddr == `HSFS_ADDR_MASK;
  assign hit_info   = paddr == `HSFS_ADDR_INFO;
  assign hit_any    = hit_status | hit_mask | hit_info;
  assign wr_mask    = acc_done & pwrite & hit_mask;
  assign rd_status  = acc_done & ~pwrite & hit_status;

  // Clear only what the read returned, so late events survive
  assign clr_bits    = rd_status ? prdata[`HSFS_EV_W-1:0] : `HSFS_MASK_RST;
  assign next_status = (status & ~clr_bits) | events;

  assign rd_val = hit_status ? {28'h000_0000, status} :
                  hit_mask   ? {28'h000_0000, mask} :
                  hit_info   ? {23'h00_0000, retry_mode, power_good,
                                retry_cnt, 3'(state)} :
                               `HSFS_DATA_ZERO;

  // No wait state: answer registered at the setup edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `HSFS_DATA_ZERO;
    end else begin
      pready  <= acc_setup;
      pslverr <= acc_setup & ~hit_any;
      prdata  <= (acc_setup & ~pwrite) ? rd_val : `HSFS_DATA_ZERO;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mask    <= `HSFS_MASK_RST;
      status  <= `HSFS_MASK_RST;
      pg_prev <= 1'b0;
      irq     <= 1'b0;
    end else begin
      if (wr_mask) begin
        mask <= pwdata[`HSFS_EV_W-1:0];
      end
      status  <= next_status;
      pg_prev <= power_good;
      irq     <= |(next_status & (wr_mask ? pwdata[`HSFS_EV_W-1:0] : mask));
    end
  end

  // Checks
  logic [`HSFS_RUN_W-1:0] low_run;

  // Helper: length of the current low drain voltage run
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      low_run <= '0;
    end else if (!flags.vds_low || !supply_ok) begin
      low_run <= '0;
    end else if (~&low_run) begin
      low_run <= low_run + 1'b1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_latched_en_low;
    state == S_LATCHED && supply_ok && !flags.enable_high;
  endsequence

  sequence s_back_to_run;
    state == S_RETRY_DIS ##1 state == S_RUN;
  endsequence

  property p_latch_release;
    s_latched_en_low |=> state == S_IDLE;
  endproperty

  sequence s_expiry_latch;
    state == S_RUN && run_ok && flags.timer_upper && !retry_mode;
  endsequence

  chk_gate_needs_run: assert property (
    (gate.full_on || gate.regulate) |-> state == S_RUN && $past(run_ok))
    else $error("gate drive without enable and supply");

  chk_latch_release: assert property (p_latch_release)
    else $error("latched fault not cleared by enable low");

  chk_latch_hold: assert property (
    state == S_LATCHED && run_ok |=> state == S_LATCHED)
    else $error("latched state left without a cycle");

  chk_pg_deglitch: assert property (
    $rose(power_good) |-> $past(low_run) >= `HSFS_RUN_W'(PG_DGL_CYC - 1))
    else $error("power good released before deglitch time");

  chk_pg_drop: assert property (
    (flags.vds_high || !flags.uv_cleared) |=> !power_good)
    else $error("power good not dropped");

  chk_power_limit_program_input_pull: assert property (
    !flags.enable_high |=> power_limit_program_input_pulldown && timer.reset)
    else $error("program pin or timer not pulled down");

  chk_gate_mode: assert property (
    state == S_RUN && run_ok && !flags.timer_upper
    |=> gate.full_on == $past(flags.id_below_allowed) && !gate.strong_pd)
    else $error("gate mode does not follow current");

  chk_timer_rate: assert property (
    state == S_RUN && run_ok && !flags.timer_upper
    |=> timer.charge == $past(flags.limit_active)
        && timer.discharge == !$past(flags.limit_active))
    else $error("timer rate wrong");

  chk_latch_off: assert property (
    s_expiry_latch |=> gate.strong_pd && timer.reset && state == S_LATCHED)
    else $error("expiry did not latch off");

  chk_retry_count: assert property (
    s_back_to_run |-> $past(retry_cnt) == `HSFS_RETRY_LAST)
    else $error("restart before fifteen cycles");

  chk_supply_hold: assert property (
    !supply_ok |=> !gate.full_on && !gate.regulate && !power_good
                   && timer.reset && power_limit_program_input_pulldown && !vref_enable)
    else $error("outputs not held during supply loss");

  chk_vref_late: assert property (
    $rose(vref_enable) |-> $past(por_done && flags.uv_cleared))
    else $error("reference enabled before supply qualified");

  chk_retry_clear: assert property (
    !run_ok |=> retry_cnt == `HSFS_RETRY_ZERO)
    else $error("retry count kept after condition drop");

endmodule
`default_nettype wire

// [hsfs_load_model.sv]
// Pass transistor, timer capacitor and load model for the sequencer bench
`default_nettype none
module hsfs_load_model
  import hsfs_pkg::*;
(
  // Clock and test control
  input  wire logic        mclk,
  input  wire logic        short_cmd,
  // Controls from the sequencer
  input  wire hsfs_gate_t  gate,
  input  wire hsfs_timer_t timer,
  // Comparator results
  output logic             limit_active,
  output logic             timer_upper,
  output logic             timer_lower,
  output logic             vds_low,
  output logic             vds_high,
  output logic             id_below_allowed
);
  // Timer in tenths of a volt; charge step is ten discharge steps
  logic [5:0] lvl  = 6'h00;
  logic [3:0] vchg = 4'h0;
  wire        on   = gate.full_on | gate.regulate;

  always @(posedge mclk) begin
    if (timer.reset)
      lvl <= 6'h00;
    else if (timer.charge)
      lvl <= (lvl > 6'h1E) ? 6'h28 : lvl + 6'h0A;
    else if (timer.discharge && lvl != 6'h00)
      lvl <= lvl - 6'h01;
    // Load discharges at once when the gate is off or shorted
    if (!on || short_cmd)
      vchg <= 4'h0;
    else if (vchg != 4'h8)
      vchg <= vchg + 4'h1;
  end

  assign limit_active     = on & short_cmd;
  assign id_below_allowed = ~limit_active;
  assign timer_upper      = (lvl >= 6'h28);
  assign timer_lower      = (lvl <= 6'h0A);
  assign vds_low          = on & ~short_cmd & (vchg == 4'h8);
  assign vds_high         = (vchg < 4'h4);
endmodule
`default_nettype wire

// [hotswap_fault_sequencer_tb_top.sv]
// Self-checking bench for the hotswap fault sequencer
`default_nettype none
`include "hsfs_params.svh"
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t ns: %s", $time, m); end end
`define WAITF(c, m) begin for (wt = 0; wt < 3000 && !(c); wt++) @(posedge mclk); if (!(c)) begin n_errors++; $display("wrong value at %0t ns: %s timed out", $time, m); results(); end end
module hotswap_fault_sequencer_tb_top
  import hsfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PG_CYC  = 20;
  localparam int POR_CYC = 10;

  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        retry_mode, por_ok, uv_cleared, enable_high, plim_over_clamp, short_cmd;
  logic        p_lim, p_up, p_low, p_vlo, p_vhi, p_idb;
  logic        power_limit_program_input_pulldown, vref_enable, power_good, irq;
  hsfs_flags_t flags;
  hsfs_gate_t  gate;
  hsfs_timer_t timer;
  int          n_errors, checks_done, wt;

  assign flags = {p_lim, p_up, p_low, p_vlo, p_vhi, uv_cleared, por_ok, enable_high,
                  p_idb, plim_over_clamp};

  hsfs_sequencer #(.PG_DGL_CYC(PG_CYC), .POR_QUAL_CYC(POR_CYC)) uut (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .retry_mode(retry_mode), .flags(flags), .gate(gate), .timer(timer),
    .power_limit_program_input_pulldown(power_limit_program_input_pulldown), .vref_enable(vref_enable), .power_good(power_good),
    .irq(irq));

  hsfs_load_model load (
    .mclk(mclk), .short_cmd(short_cmd), .gate(gate), .timer(timer), .limit_active(p_lim),
    .timer_upper(p_up), .timer_lower(p_low), .vds_low(p_vlo), .vds_high(p_vhi),
    .id_below_allowed(p_idb));

  task automatic results();
    $display("checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One APB transfer, entered just after a rising edge; idles one cycle after
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    `WAITF(k < 20, "bus answer")
    @(posedge mclk);
  endtask

  task automatic t_power_up();
    por_ok <= 1'b1; uv_cleared <= 1'b1;
    repeat (POR_CYC - 1) begin
      @(posedge mclk);
      `CHK(vref_enable, 1'b0, "reference before qualification")
    end
    `WAITF(vref_enable === 1'b1, "reference on")
    @(posedge mclk);
    `CHK(gate.full_on, 1'b0, "gate on without enable")
    `CHK(gate.weak_pd, 1'b1, "weak pulldown with enable low")
    `CHK(power_limit_program_input_pulldown, 1'b1, "program pin with enable low")
  endtask

  task automatic t_start();
    int n;
    apb(1'b1, `HSFS_ADDR_MASK, 32'h0000_0002);
    enable_high <= 1'b1;
    `WAITF(gate.full_on === 1'b1, "gate turn-on")
    `CHK(power_limit_program_input_pulldown, 1'b0, "program pin released")
    `CHK(timer.discharge, 1'b1, "slow discharge without limit")
    `CHK(gate.ref_clamp, 1'b0, "clamp without request")
    `WAITF(p_vlo === 1'b1, "load charge")
    for (n = 0; n < 40 && power_good !== 1'b1; n++) @(posedge mclk);
    `CHK(n >= PG_CYC && n <= PG_CYC + 2, 1'b1, "power good delay")
    `WAITF(irq === 1'b1, "interrupt")
    apb(1'b0, `HSFS_ADDR_STATUS, 32'h0000_0000);
    `CHK(rd[3:0], 4'h2, "status after power good")
    @(posedge mclk);
    `CHK(irq, 1'b0, "interrupt after status read")
    apb(1'b0, `HSFS_ADDR_STATUS, 32'h0000_0000);
    `CHK(rd[3:0], 4'h0, "status not cleared")
  endtask

  task automatic t_latch();
    retry_mode <= 1'b0; plim_over_clamp <= 1'b1; short_cmd <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK(power_good, 1'b0, "power good in overload")
    `CHK(gate.regulate, 1'b1, "gate regulation")
    `CHK(timer.charge, 1'b1, "timer charge in limit")
    `CHK(gate.ref_clamp, 1'b1, "current ceiling clamp")
    `WAITF(gate.strong_pd === 1'b1, "latch-off")
    short_cmd <= 1'b0; plim_over_clamp <= 1'b0;
    repeat (40) @(posedge mclk);
    `CHK(gate.full_on, 1'b0, "latched gate on")
    `CHK(timer.reset, 1'b1, "latched timer discharge")
    `CHK(power_limit_program_input_pulldown, 1'b1, "program pin when latched")
    apb(1'b0, `HSFS_ADDR_STATUS, 32'h0000_0000);
    `CHK(rd[0], 1'b1, "fault status")
    enable_high <= 1'b0;
    repeat (3) @(posedge mclk);
    enable_high <= 1'b1;
    `WAITF(gate.full_on === 1'b1, "restart after enable cycle")
    `CHK(gate.full_on, 1'b1, "latch cleared by enable")
  endtask

  task automatic t_retry();
    int n, k;
    logic prev;
    retry_mode <= 1'b1; short_cmd <= 1'b1;
    `WAITF(gate.strong_pd === 1'b1, "retry expiry")
    n = 0;
    prev = 1'b0;
    for (k = 0; k < 3000; k++) begin
      @(posedge mclk);
      if (gate.full_on | gate.regulate) break;
      if (timer.charge === 1'b1 && !prev) n++;
      prev = timer.charge;
    end
    short_cmd <= 1'b0;
    `CHK(n, 15, "retry charge cycles")
    apb(1'b0, `HSFS_ADDR_STATUS, 32'h0000_0000);
    `CHK(rd[3], 1'b1, "restart status")
  endtask

  task automatic t_undervoltage_lockout();
    `WAITF(power_good === 1'b1, "power good return")
    uv_cleared <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK(power_good, 1'b0, "power good in undervoltage")
    `CHK(gate.weak_pd, 1'b1, "weak pulldown in undervoltage")
    `CHK(timer.reset, 1'b1, "timer in undervoltage")
    `CHK(vref_enable, 1'b0, "reference in undervoltage")
    apb(1'b0, `HSFS_ADDR_INFO, 32'h0000_0000);
    `CHK(rd[6:3], 4'h0, "retry count kept")
    `CHK(rd[8], 1'b1, "mode readback")
    uv_cleared <= 1'b1;
    `WAITF(power_good === 1'b1, "power good after undervoltage")
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK(err, 1'b1, "unmapped error")
    `CHK(rd, 32'h0000_0000, "unmapped data")
    apb(1'b0, `HSFS_ADDR_MASK, 32'h0000_0000);
    `CHK(rd, 32'h0000_0002, "mask readback")
    // Cut a retry sequence short by dropping enable
    short_cmd <= 1'b1;
    `WAITF(gate.strong_pd === 1'b1, "second expiry")
    short_cmd <= 1'b0;
    `WAITF(timer.charge === 1'b1, "retry recharge")
    `WAITF(timer.discharge === 1'b1, "retry count step")
    apb(1'b0, `HSFS_ADDR_INFO, 32'h0000_0000);
    `CHK(rd[6:3], 4'h1, "retry count after one charge")
    `CHK(rd[2:0], 3'h2, "state code during retry discharge")
    enable_high <= 1'b0;
    @(posedge mclk);
    apb(1'b0, `HSFS_ADDR_INFO, 32'h0000_0000);
    `CHK(rd[6:3], 4'h0, "retry count after enable drop")
    `CHK(rd[2:0], 3'h1, "state code after enable drop")
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; retry_mode = 1'b0; por_ok = 1'b0; uv_cleared = 1'b0;
    enable_high = 1'b0; plim_over_clamp = 1'b0; short_cmd = 1'b0;
    n_errors = 0; checks_done = 0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_power_up();
    t_start();
    t_latch();
    t_retry();
    t_undervoltage_lockout();
    results();
  end

  // Cuts a hang short
  initial begin
    #2000000;
    n_errors++;
    $display("wrong value at %0t ns: run timed out", $time);
    results();
  end
endmodule
`default_nettype wire
